// ---- dv/emt_ctrl_chk.sv ----
/*
 Pin timing checker bound to emt_ctrl.
 Assumes one clock and the active-low rstn port.
*/
`timescale 1ns/1ns
`default_nettype none
module emt_ctrl_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Move port
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic rspValid,
   // Pins
   input wire emt_pkg::emt_byte_t memAddrHiOut,
   input wire emt_pkg::emt_byte_t memAddrLoOut,
   input wire logic memAddrLoOe,
   input wire logic memDataOe,
   input wire logic memAle,
   input wire logic memRdN,
   input wire logic memWrN
);
   import emt_pkg::*;
   // **********
   // Checks
   // **********
   logic stbLow;
   logic [4:0] stbCnt_q;
   logic [2:0] aleCnt_q;
   assign stbLow = !memRdN || !memWrN;
   // Run lengths of strobe and latch pulses
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn) stbCnt_q <= 5'h00;
      else stbCnt_q <= stbLow ? stbCnt_q + 5'h01 : 5'h00;
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn) aleCnt_q <= 3'h0;
      else aleCnt_q <= memAle ? aleCnt_q + 3'h1 : 3'h0;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   strobe_excl_a: assert property (memRdN || memWrN)
      else $error("both strobes low");
   idle_strobes_a: assert property (reqReady |-> memRdN && memWrN)
      else $error("strobe low while idle");
   read_release_a: assert property (!memRdN |-> !memDataOe)
      else $error("data driven during read");
   write_data_a: assert property (!memWrN |-> memDataOe)
      else $error("write strobe without data");
   strobe_max_a: assert property (stbLow |-> stbCnt_q < 5'h10)
      else $error("strobe longer than sixteen");
   latch_max_a: assert property (memAle |-> aleCnt_q < 3'h4)
      else $error("latch pulse longer than four");
   latch_gap_a: assert property ($fell(memAle) |-> memRdN && memWrN)
      else $error("strobe right after latch");
   strobe_addr_a: assert property (stbLow && $past(stbLow) |->
      $stable(memAddrHiOut) && (!memAddrLoOe || $stable(memAddrLoOut)))
      else $error("address moved in strobe");
   rsp_pulse_a: assert property (rspValid |=> !rspValid)
      else $error("response longer than one cycle");
   accept_busy_a: assert property (reqValid && reqReady |=> !reqReady)
      else $error("ready right after accept");
   mux_move_c: cover property (memAle ##[1:8] !memWrN);
   write_move_c: cover property (!memWrN ##1 memWrN);
   read_move_c: cover property (!memRdN ##1 memRdN);
endmodule : emt_ctrl_chk
bind emt_ctrl emt_ctrl_chk chk (.sys_clk, .rstn, .reqValid, .reqReady, .rspValid, .memAddrHiOut,
   .memAddrLoOut, .memAddrLoOe, .memDataOe, .memAle, .memRdN, .memWrN);
`default_nettype wire

// ---- dv/emt_mem_model.sv ----
/*
 Asynchronous byte memory on the far side of the pins.
 Assumes low address on the data lines while the latch pulse is high.
*/
`timescale 1ns/1ns
`default_nettype none
module emt_mem_model (
   // Clock
   input wire logic sys_clk,
   // Pins from the controller
   input wire emt_pkg::emt_byte_t memAddrLoOut,
   input wire logic memAddrLoOe,
   input wire emt_pkg::emt_byte_t memDataOut,
   input wire logic memAle,
   input wire logic memRdN,
   input wire logic memWrN,
   // Pins to the controller
   output emt_pkg::emt_byte_t memDataIn
);
   import emt_pkg::*;
   // **********
   // Storage
   // **********
   emt_byte_t cells [256];
   emt_byte_t addrLatch_q = 8'h00;
   emt_byte_t lastOut_q = 8'h00;
   emt_byte_t addr;
   assign addr = memAddrLoOe ? memAddrLoOut : addrLatch_q;
   always_ff @(posedge sys_clk)
   begin
      if (memAle) addrLatch_q <= memDataOut;
      if (!memWrN) cells[addr] <= memDataOut;
      if (!memRdN) lastOut_q <= memDataIn;
   end
   // Released bus shows the inverse, never a stale copy
   assign memDataIn = !memRdN ? cells[addr] : ~lastOut_q;
endmodule : emt_mem_model
`default_nettype wire

// ---- dv/external_memory_strobe_timing_bench.sv ----
/*
 Self-checking bench: AHB-Lite register access and core moves.
 Assumes emt_ctrl, emt_mem_model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module external_memory_strobe_timing_bench;
   import emt_pkg::*;
   // **********
   // Wiring
   // **********
   logic sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic reqValid = 1'b0, reqWrite = 1'b0, reqWide = 1'b0, hiOe, ce = 1'b1;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] reqAddr = 16'h0;
   emt_byte_t reqWdata = 8'h00, hi;
   wire logic hready, hreadyout, hresp, reqReady, rspValid, memAddrHiOe, memAddrLoOe, memDataOe, memAle, memRdN, memWrN;
   wire logic [31:0] hrdata;
   wire emt_byte_t rspRdata, memAddrHiOut, memAddrLoOut, memDataOut, memDataIn;
   int miscompares = 0, compares = 0, k, stb, ale, pre, post, hld;
   assign hready = hreadyout;
   initial forever #25 sys_clk = ~sys_clk;
   emt_ctrl uut (.sys_clk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .reqValid, .reqReady, .reqWrite, .reqWide, .reqAddr, .reqWdata, .rspValid,
      .rspRdata, .memAddrHiOut, .memAddrHiOe, .memAddrLoOut, .memAddrLoOe, .memDataOut, .memDataOe, .memDataIn,
      .memAle, .memRdN, .memWrN);
   emt_mem_model mem (.sys_clk, .memAddrLoOut, .memAddrLoOe, .memDataOut, .memAle, .memRdN, .memWrN, .memDataIn);
   // **********
   // Tasks
   // **********
   task automatic report_and_stop();
      $display("miscompares %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk_n(input int got, input int exp);
      compares++;
      if (got != exp)
      begin
         miscompares++;
         $display("unexpected at %0t: count %0d not %0d", $time, got, exp);
      end
   endtask : chk_n
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: value %h not %h", $time, got, exp);
      end
   endtask : chk_v
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Counts cycle by cycle from the accept edge to the response
   task automatic move(input logic wr, input logic wide, input logic [15:0] a, input emt_byte_t wd);
      logic seen;
      seen = 1'b0;
      {k, stb, ale, pre, post, hld} = '0;
      hiOe = 1'b0;
      @(posedge sys_clk);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqWide <= wide;
      reqAddr <= a;
      reqWdata <= wd;
      do @(posedge sys_clk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         k++;
         if (memRdN === 1'b0 || memWrN === 1'b0)
         begin
            stb++;
            seen = 1'b1;
            hiOe = memAddrHiOe;
            hi = memAddrHiOut;
         end
         else if (memDataOe === 1'b1)
         begin
            if (seen) post++;
            else pre++;
         end
         if (memAle === 1'b1) ale++;
         if (seen && memRdN === 1'b1 && memWrN === 1'b1 && memAddrLoOe === 1'b1) hld++;
      end while (rspValid !== 1'b1 && k < 200);
   endtask : move
   // **********
   // Tests
   // **********
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      logic [31:0] rd;
      logic [7:0] hb, wd, pg, tm;
      logic [2:0] md;
      logic mux, wide;
      int s, w, h, n;
      logic [2:0] modeT [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
      logic [7:0] tmT [6] = '{8'h00, 8'hff, 8'h4d, 8'h00, 8'hff, 8'h96};
      logic [1:0] latT [6] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h2, 2'h0};
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk_v(rd, 32'hff);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk_v(rd, 32'h0);
      chk_v(32'(hresp), 32'h0);
      move(1'b1, 1'b1, 16'h1234, 8'h55);
      chk_n(stb, 0);
      ahb(1'b1, 8'h04, 32'hff, rd);
      ahb(1'b0, 8'h04, 32'h0, rd);
      chk_v(rd, 32'h1f);
      for (int i = 0; i < 6; i++)
      begin
         md = modeT[i];
         tm = tmT[i];
         hb = 8'h70 + 8'(i);
         pg = 8'ha0 + 8'(i);
         ahb(1'b1, 8'h00, 32'(tm), rd);
         ahb(1'b1, 8'h04, 32'({md, latT[i]}), rd);
         ahb(1'b1, 8'h08, 32'(pg), rd);
         s = tm[7:6];
         w = tm[5:2];
         h = tm[1:0];
         mux = !md[2];
         n = s + w + h + 5 + (mux ? 2 * (latT[i] + 1) : 0);
         for (int j = 0; j < 4; j++)
         begin
            wide = j[1];
            wd = 8'hc0 + 8'(i * 2 + j);
            if (j[0]) wd = wd - 8'h01;
            move(!j[0], wide, {hb, 7'h10, wide}, wd);
            chk_n(k, n - 1);
            chk_n(stb, w + 1);
            chk_n(ale, mux ? latT[i] + 1 : 0);
            chk_v(32'(hiOe), 32'(wide || md[1:0] == 2'h2));
            if (wide || md[1:0] == 2'h2) chk_v(32'(hi), 32'(wide ? hb : pg));
            if (!j[0]) chk_n(post, h);
            if (!j[0] && !mux) chk_n(pre, s);
            if (!j[0] && mux) chk_n(pre - ale, s + latT[i] + 1);
            if (!mux) chk_n(hld, h);
            if (j[0]) chk_v(32'(rspRdata), 32'(wd));
         end
      end
      // Clock enable low for four edges stretches the move by four
      fork
         move(1'b1, 1'b0, 16'h0020, 8'h5a);
         begin
            repeat (3) @(posedge sys_clk);
            ce <= 1'b0;
            repeat (4) @(posedge sys_clk);
            ce <= 1'b1;
         end
      join
      chk_n(k, n + 3);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk_v(rd, 32'h0000_cc0e);
      ahb(1'b1, 8'h04, 32'h10, rd);
      move(1'b0, 1'b0, 16'h0042, 8'h00);
      chk_n(k, 1);
      report_and_stop();
   end
endmodule : external_memory_strobe_timing_bench
`default_nettype wire

// ---- hdl/emt_ctrl.sv ----
/*
 External memory strobe timing block: AHB-Lite register slave, move sequencer
 and pin drive for an off-chip parallel memory.
 Assumes the core only issues off-chip moves, one at a time, and that the board
 resolves pin levels from the output enables.
*/
`timescale 1ns/1ns
`default_nettype none
`include "emt_map.svh"
module emt_ctrl #(
   parameter int HADDR_W = 8
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [HADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Core move request
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqWrite,
   input wire logic reqWide,
   input wire logic [15:0] reqAddr,
   input wire emt_pkg::emt_byte_t reqWdata,
   output logic rspValid,
   output emt_pkg::emt_byte_t rspRdata,
   // Memory pins
   output emt_pkg::emt_byte_t memAddrHiOut,
   output logic memAddrHiOe,
   output emt_pkg::emt_byte_t memAddrLoOut,
   output logic memAddrLoOe,
   output emt_pkg::emt_byte_t memDataOut,
   output logic memDataOe,
   input wire emt_pkg::emt_byte_t memDataIn,
   output logic memAle,
   output logic memRdN,
   output logic memWrN
);
   import emt_pkg::*;

   if (HADDR_W < 4 || HADDR_W > 32)
   begin : gBadAddrWidth
      $error("emt_ctrl: HADDR_W must be 4 to 32");
   end

   // ****************************************
   // Reset release
   // ****************************************
   logic rstMeta_q;
   logic rstSync_q;
   logic rstnI;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   assign rstnI = rstSync_q;

   // ****************************************
   // Register bus
   // ****************************************
   logic [7:0] timing_q;
   logic [7:0] config_q;
   logic [7:0] page_q;
   logic [7:0] rdata_q;
   logic [7:0] busAddr_q;
   logic busWrite_q;
   logic busRead_q;
   logic busTake;
   logic [7:0] busAddrByte;
   logic selTiming;
   logic selConfig;
   logic selPage;
   logic selStatus;
   logic [31:0] statusWord;

   assign busTake = hsel && htrans[1] && hready;
   // Only the low byte is decoded; wider buses alias
   assign busAddrByte = 8'(haddr);
   assign selTiming = busAddr_q == `EMT_OFF_TIMING;
   assign selConfig = busAddr_q == `EMT_OFF_CONFIG;
   assign selPage = busAddr_q == `EMT_OFF_PAGE;
   assign selStatus = busAddr_q == `EMT_OFF_STATUS;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge sys_clk or negedge rstnI)
   begin
      if (!rstnI)
      begin
         busAddr_q <= 8'h00;
         busWrite_q <= 1'b0;
         busRead_q <= 1'b0;
      end
      else if (ce && hready)
      begin
         busAddr_q <= busAddrByte;
         busWrite_q <= busTake && hwrite;
         busRead_q <= busTake && !hwrite;
      end
   end

   always_ff @(posedge sys_clk or negedge rstnI)
   begin
      if (!rstnI)
      begin
         timing_q <= `EMT_RST_TIMING; // RULE15
         config_q <= `EMT_RST_CONFIG;
         page_q <= `EMT_RST_PAGE;
      end
      else if (ce && busWrite_q)
      begin
         if (selTiming) timing_q <= hwdata[7:0];
         if (selConfig) config_q <= {3'h0, hwdata[4:0]};
         if (selPage) page_q <= hwdata[7:0];
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   logic [2:0] modeField;
   logic offChip;
   logic nonMux;
   logic bankSel;

   assign modeField = config_q[`EMT_CF_MODE_LSB +: 3];
   assign offChip = modeField[1:0] != 2'b00;
   assign nonMux = modeField[2]; // RULE3 RULE6
   assign bankSel = modeField[1:0] == 2'b10; // RULE5 RULE8

   // ****************************************
   // Move sequencer
   // ****************************************
   emt_state_e state_q;
   emt_state_e state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [1:0] setup_q;
   logic [3:0] width_q;
   logic [1:0] hold_q;
   logic [1:0] aleW_q;
   logic write_q;
   logic mux_q;
   logic hiDrive_q;
   logic [15:0] addr_q;
   logic [7:0] wdata_q;
   logic phaseDone;
   logic accept;
   logic [3:0] setupLen;
   logic [3:0] holdLen;
   logic [3:0] aleLen;
   logic [3:0] widthLen;

   assign reqReady = ce && (state_q == EMT_IDLE);
   assign accept = reqValid && reqReady;
   assign phaseDone = cnt_q == 4'h0;
   assign setupLen = {2'b00, setup_q} - 4'h1;
   assign holdLen = {2'b00, hold_q} - 4'h1;
   assign aleLen = {2'b00, aleW_q};
   assign widthLen = width_q;
   assign rspValid = (state_q == EMT_TAIL) && phaseDone && ce; // RULE16

   always_comb
   begin
      state_d = state_q;
      cnt_d = phaseDone ? cnt_q : cnt_q - 4'h1;
      case (state_q)
         EMT_IDLE:
         begin
            if (accept)
            begin
               if (!offChip)
               begin
                  state_d = EMT_TAIL;
                  cnt_d = 4'h0;
               end
               else if (!nonMux)
               begin
                  state_d = EMT_ALEH;
                  cnt_d = {2'b00, config_q[`EMT_CF_ALE_LSB +: 2]}; // RULE9
               end
               else if (timing_q[`EMT_TC_SETUP_LSB +: 2] != 2'b00)
               begin
                  state_d = EMT_SETUP;
                  cnt_d = {2'b00, timing_q[`EMT_TC_SETUP_LSB +: 2]} - 4'h1; // RULE13
               end
               else
               begin
                  state_d = EMT_STROBE;
                  cnt_d = timing_q[`EMT_TC_WIDTH_LSB +: 4]; // RULE1 RULE14
               end
            end
         end
         EMT_ALEH:
         begin
            if (phaseDone)
            begin
               state_d = EMT_ALEL;
               cnt_d = aleLen; // RULE10
            end
         end
         EMT_ALEL:
         begin
            if (phaseDone)
            begin
               state_d = (setup_q != 2'b00) ? EMT_SETUP : EMT_STROBE;
               cnt_d = (setup_q != 2'b00) ? setupLen : widthLen; // RULE13
            end
         end
         EMT_SETUP:
         begin
            if (phaseDone)
            begin
               state_d = EMT_STROBE;
               cnt_d = widthLen; // RULE1
            end
         end
         EMT_STROBE:
         begin
            if (phaseDone)
            begin
               state_d = (hold_q != 2'b00) ? EMT_HOLD : EMT_TAIL;
               cnt_d = (hold_q != 2'b00) ? holdLen : `EMT_TAIL_CYCLES - 4'h1; // RULE2
            end
         end
         EMT_HOLD:
         begin
            if (phaseDone)
            begin
               state_d = EMT_TAIL;
               cnt_d = `EMT_TAIL_CYCLES - 4'h1; // RULE16
            end
         end
         EMT_TAIL:
         begin
            if (phaseDone) state_d = EMT_IDLE;
         end
         default:
         begin
            state_d = EMT_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstnI)
   begin
      if (!rstnI)
      begin
         state_q <= EMT_IDLE;
         cnt_q <= 4'h0;
      end
      else if (ce)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Snapshot so register writes mid-move cannot distort a strobe
   always_ff @(posedge sys_clk or negedge rstnI)
   begin
      if (!rstnI)
      begin
         setup_q <= 2'b00;
         width_q <= 4'h0;
         hold_q <= 2'b00;
         aleW_q <= 2'b00;
         write_q <= 1'b0;
         mux_q <= 1'b0;
         hiDrive_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
      end
      else if (ce && accept)
      begin
         setup_q <= timing_q[`EMT_TC_SETUP_LSB +: 2];
         width_q <= timing_q[`EMT_TC_WIDTH_LSB +: 4];
         hold_q <= timing_q[`EMT_TC_HOLD_LSB +: 2];
         aleW_q <= config_q[`EMT_CF_ALE_LSB +: 2];
         write_q <= reqWrite;
         mux_q <= !nonMux;
         hiDrive_q <= reqWide || bankSel; // RULE4 RULE7
         addr_q <= {(reqWide ? reqAddr[15:8] : page_q), reqAddr[7:0]}; // RULE5 RULE8
         wdata_q <= reqWdata;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   logic activePh;
   logic aleAddrPh;
   logic dataPh;
   logic strobePh;

   assign activePh = (state_q == EMT_ALEH) || (state_q == EMT_ALEL) || dataPh;
   assign aleAddrPh = (state_q == EMT_ALEH) || (state_q == EMT_ALEL);
   assign dataPh = (state_q == EMT_SETUP) || (state_q == EMT_STROBE) || (state_q == EMT_HOLD);
   assign strobePh = state_q == EMT_STROBE;

   assign memAddrHiOut = addr_q[15:8];
   assign memAddrHiOe = activePh && hiDrive_q; // RULE4 RULE5 RULE7 RULE8
   assign memAddrLoOut = addr_q[7:0];
   assign memAddrLoOe = activePh && !mux_q; // RULE3 RULE2
   // Shared lines carry the low address while the latch runs, then data
   assign memDataOut = aleAddrPh ? addr_q[7:0] : wdata_q; // RULE6
   assign memDataOe = (mux_q && aleAddrPh) || (write_q && dataPh); // RULE11 RULE12
   assign memAle = state_q == EMT_ALEH; // RULE9 RULE10
   assign memRdN = !(strobePh && !write_q); // RULE17
   assign memWrN = !(strobePh && write_q); // RULE17

   // ****************************************
   // Read capture
   // ****************************************
   emt_byte_t dataSync;
   logic [`EMT_CAPTURE_DELAY-1:0] capPipe_q;
   logic capStart;

   emt_sync #(
      .WIDTH(8)
   ) uDataSync (
      .clk(sys_clk),
      .rstn(rstnI),
      .ce(ce),
      .din(memDataIn),
      .dout(dataSync)
   );

   // Pin value at the last strobe cycle emerges two edges later
   assign capStart = strobePh && phaseDone && !write_q;

   always_ff @(posedge sys_clk or negedge rstnI)
   begin
      if (!rstnI)
      begin
         capPipe_q <= '0;
         rdata_q <= 8'h00;
      end
      else if (ce)
      begin
         capPipe_q <= {capPipe_q[`EMT_CAPTURE_DELAY-2:0], capStart};
         if (capPipe_q[`EMT_CAPTURE_DELAY-1]) rdata_q <= dataSync;
      end
   end

   assign rspRdata = rdata_q;

   // ****************************************
   // Read data
   // ****************************************
   assign statusWord = {16'h0000, rdata_q, 4'h0, modeField, (state_q != EMT_IDLE)};
   assign hrdata = !busRead_q ? 32'h0000_0000 :
                   selTiming ? {24'h000000, timing_q} :
                   selConfig ? {24'h000000, config_q} :
                   selPage ? {24'h000000, page_q} :
                   selStatus ? statusWord : 32'h0000_0000;
endmodule : emt_ctrl
`default_nettype wire

// ---- hdl/emt_sync.sv ----
/*
 Two-stage synchroniser for a bus of pin inputs.
 Assumes the caller's clock enable and synchronised active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module emt_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   if (WIDTH < 1)
   begin : gBadWidth
      $error("emt_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else if (ce)
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : emt_sync
`default_nettype wire

// ---- pkg/emt_map.svh ----
/*
 Register offsets, field positions, reset values and timing counts of the
 external memory strobe timing block. Assumes a 32-bit AHB-Lite register bus.
*/
// Operation
// RULE1 - Strobe width field plus one gives the strobe low time in cycles.
// RULE2 - Address hold field keeps address stable 0 to 3 cycles after strobe.
// RULE3 - Configuration 101, 110, 111: wide moves use non-multiplexed timing.
// RULE4 - Configuration 101, 111: narrow moves non-multiplexed, upper byte undriven.
// RULE5 - Configuration 110: narrow moves non-multiplexed, upper byte from page register.
// RULE6 - Configuration 001, 010, 011: wide moves multiplexed, low byte latched by pulse.
// RULE7 - Configuration 001, 011: narrow moves multiplexed, upper byte undriven.
// RULE8 - Configuration 010: narrow moves multiplexed, upper byte from page register.
// RULE9 - Multiplexed latch pulse stays high for 1 to 4 cycles.
// RULE10 - Multiplexed latch stays low 1 to 4 cycles before strobe phase.
// RULE11 - Write data presented 1 to 19 cycles before write strobe ends.
// RULE12 - Write data kept 0 to 3 cycles after write strobe, per hold.
// RULE13 - Address setup field inserts 0 to 3 cycles before strobe.
// RULE14 - Strobe width field zero gives exactly one cycle strobe.
// RULE15 - Timing register resets to all ones.
// RULE16 - Move lasts setup plus strobe plus hold plus four, plus latch cycles.
// RULE17 - Strobes active low, one per move, both high while idle.
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define EMT_OFF_TIMING 8'h00
`define EMT_OFF_CONFIG 8'h04
`define EMT_OFF_PAGE 8'h08
`define EMT_OFF_STATUS 8'h0c
// ****************************************
// Field positions
// ****************************************
`define EMT_TC_SETUP_LSB 6
`define EMT_TC_WIDTH_LSB 2
`define EMT_TC_HOLD_LSB 0
`define EMT_CF_MODE_LSB 2
`define EMT_CF_ALE_LSB 0
`define EMT_ST_BUSY_BIT 0
`define EMT_ST_MODE_LSB 1
`define EMT_ST_RDATA_LSB 8
// ****************************************
// Reset values
// ****************************************
`define EMT_RST_TIMING 8'hff
`define EMT_RST_CONFIG 8'h00
`define EMT_RST_PAGE 8'h00
// ****************************************
// Timing counts
// ****************************************
`define EMT_TAIL_CYCLES 4'h3
`define EMT_CAPTURE_DELAY 2
`endif

// ---- pkg/emt_pkg.sv ----
/*
 Types of the external memory strobe timing block.
 Assumes emt_map.svh holds the numbers.
*/
package emt_pkg;
   typedef enum logic [6:0] {
      EMT_IDLE = 7'b0000001,
      EMT_ALEH = 7'b0000010,
      EMT_ALEL = 7'b0000100,
      EMT_SETUP = 7'b0001000,
      EMT_STROBE = 7'b0010000,
      EMT_HOLD = 7'b0100000,
      EMT_TAIL = 7'b1000000
   } emt_state_e;
   typedef logic [7:0] emt_byte_t;
endpackage : emt_pkg
